// ===== src/rwdt_core_if.sv
`timescale 1ns/1ps
`default_nettype none
// control side to counter core
interface rwdt_core_if;
  logic run;
  logic clr;
  logic rst_en;
  logic [1:0] sel;
  logic ovf;
  logic rst_active;
  logic [21:0] count;
  modport core (input run, clr, rst_en, sel, output ovf, rst_active, count);
  modport ctrl (output run, clr, rst_en, sel, input ovf, rst_active, count);
endinterface
`default_nettype wire

// ===== src/rwdt_counter.sv
`timescale 1ns/1ps
`default_nettype none
module rwdt_counter
  import rwdt_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control side
  rwdt_core_if.core cif
);
  // ****************************************
  // binary counter
  // ****************************************
  logic [RWDT_CNT_W-1:0] cnt_r;
  logic [RWDT_CNT_W-1:0] tap_mask;
  logic [4:0] rst_cnt_r;
  logic [4:0] rst_len_seen_r;

  // tap mask: all bits below the selected tap
  always_comb
  begin
    tap_mask = (RWDT_CNT_W'(1) << (RWDT_TAP_BASE + RWDT_TAP_STEP * int'(cif.sel)))
      - RWDT_CNT_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else if (cif.clr)
      cnt_r <= '0;
    else if (cif.run)
      cnt_r <= cnt_r + RWDT_CNT_W'(1);
  end

  // overflow is the carry into the selected tap
  assign cif.ovf = cif.run && !cif.clr && ((cnt_r & tap_mask) == tap_mask);
  assign cif.count = cnt_r;

  // reset stretch, restarted by each connected overflow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_cnt_r <= '0;
    else if (cif.ovf && cif.rst_en)
      rst_cnt_r <= RWDT_RST_LEN;
    else if (rst_cnt_r != 5'h00)
      rst_cnt_r <= rst_cnt_r - 5'h01;
  end
  assign cif.rst_active = (rst_cnt_r != 5'h00);

  // length of the current reset pulse, for checking only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_len_seen_r <= '0;
    else if (cif.rst_active)
      rst_len_seen_r <= rst_len_seen_r + 5'h01;
    else
      rst_len_seen_r <= '0;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_count_step;
    cif.run && !cif.clr |=> cnt_r == $past(cnt_r) + RWDT_CNT_W'(1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_tap_ovf;
    cif.ovf |-> ((cnt_r & tap_mask) == tap_mask) ##1 ((cnt_r & tap_mask) == '0);
  endproperty
  a_tap_ovf: assert property (p_tap_ovf) else $error("overflow not at tap");

  property p_clear;
    cif.clr |=> cnt_r == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear code did not zero counter");

  property p_rst_len;
    $fell(cif.rst_active) && !$past(cif.ovf) |->
      ($past(rst_len_seen_r) >= 5'(RWDT_RST_MIN_STATES - 1))
      && ($past(rst_len_seen_r) <= 5'(RWDT_RST_MAX_STATES - 1));
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
endmodule
`default_nettype wire

// ===== src/rwdt_pkg.sv
package rwdt_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] RWDT_MODE_OFS = 8'h00;
  localparam logic [7:0] RWDT_CMD_OFS = 8'h04;
  localparam logic [7:0] RWDT_STAT_OFS = 8'h08;
  localparam logic [7:0] RWDT_MASK_OFS = 8'h0c;
  // mode fields
  localparam int RWDT_EN_BIT = 7;
  localparam int RWDT_SEL_LSB = 5;
  localparam int RWDT_I2RUN_BIT = 3;
  localparam int RWDT_RCON_BIT = 2;
  localparam logic RWDT_EN_RST = 1'b1;
  localparam logic [1:0] RWDT_SEL_RST = 2'h0;
  localparam logic RWDT_I2RUN_RST = 1'b0;
  localparam logic RWDT_RCON_RST = 1'b0;
  // command codes
  localparam logic [7:0] RWDT_CODE_CLEAR = 8'h4e;
  localparam logic [7:0] RWDT_CODE_DISABLE = 8'hb1;
  // status bits
  localparam int RWDT_ST_OVF = 0;
  localparam int RWDT_ST_RST = 1;
  localparam logic [1:0] RWDT_STAT_RST = 2'h0;
  localparam logic [1:0] RWDT_MASK_RST = 2'h0;
  // ****************************************
  // counter and reset timing
  // ****************************************
  localparam int RWDT_CNT_W = 22;
  localparam int RWDT_TAP_BASE = 15;
  localparam int RWDT_TAP_STEP = 2;
  localparam int RWDT_RST_MIN_STATES = 22;
  localparam int RWDT_RST_MAX_STATES = 29;
  localparam logic [4:0] RWDT_RST_LEN = 5'(RWDT_RST_MIN_STATES);
endpackage

// ===== src/rwdt_top.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rwdt_top
  import rwdt_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // low-power state pins
  input wire logic lp_idle1_stop,
  input wire logic lp_idle2,
  // watchdog outputs
  output logic watchdog_overflow_irq,
  output logic wdt_out,
  output logic wdt_reset,
  output logic irq
);
  import rwdt_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [1:0] lp_meta_r;
  logic [1:0] lp_sync_r;
  logic mode_en_r;
  logic [1:0] detection_time_select_r;
  logic idle2_run_bit_r;
  logic reset_connect_bit_r;
  logic disabled_r;
  logic [1:0] status_r;
  logic [1:0] status_nxt;
  logic [1:0] mask_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic nmi_r;
  logic wdt_out_r;
  logic wdt_reset_r;
  logic irq_r;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic halt;
  logic [7:0] wbyte;
  logic [31:0] rd_mux;
  rwdt_core_if cif ();

  // ****************************************
  // pin synchronisers
  // ****************************************
  // two flops per low-power pin, first flop read only by the second
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          lp_meta_r[i] <= 1'b0;
          lp_sync_r[i] <= 1'b0;
        end
        else
        begin
          lp_meta_r[i] <= (i == 0) ? lp_idle1_stop : lp_idle2;
          lp_sync_r[i] <= lp_meta_r[i];
        end
      end
    end
  endgenerate

  // ****************************************
  // apb decode
  // ****************************************
  // one wait state: pready rises in the second access cycle
  assign acc_done = psel && penable && pready_r;
  assign wr_done = acc_done && pwrite;
  assign rd_done = acc_done && !pwrite;
  assign wbyte = pwdata[7:0];

  // address decode, unmapped answers with an error
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      ADDR_W'(RWDT_MODE_OFS):
      begin
        rd_mux[RWDT_EN_BIT] = mode_en_r;
        rd_mux[RWDT_SEL_LSB +: 2] = detection_time_select_r;
        rd_mux[RWDT_I2RUN_BIT] = idle2_run_bit_r;
        rd_mux[RWDT_RCON_BIT] = reset_connect_bit_r;
      end
      ADDR_W'(RWDT_CMD_OFS):
        rd_mux = 32'h0000_0000; // write-only, reads zero
      ADDR_W'(RWDT_STAT_OFS):
        rd_mux[1:0] = status_r;
      ADDR_W'(RWDT_MASK_OFS):
        rd_mux[1:0] = mask_r;
      default:
        mapped = 1'b0;
    endcase
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else if (psel && penable && !pready_r)
    begin
      pready_r <= 1'b1;
      pslverr_r <= !mapped;
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
    end
    else
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
  end

  // ****************************************
  // mode register
  // ****************************************
  // reset values of mode fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_en_r <= RWDT_EN_RST;
      detection_time_select_r <= RWDT_SEL_RST;
      idle2_run_bit_r <= RWDT_I2RUN_RST;
      reset_connect_bit_r <= RWDT_RCON_RST;
    end
    else if (wr_done && paddr == ADDR_W'(RWDT_MODE_OFS))
    begin
      mode_en_r <= wbyte[RWDT_EN_BIT];
      detection_time_select_r <= wbyte[RWDT_SEL_LSB +: 2];
      idle2_run_bit_r <= wbyte[RWDT_I2RUN_BIT];
      reset_connect_bit_r <= wbyte[RWDT_RCON_BIT];
    end
  end

  // ****************************************
  // enable / disable sequence
  // ****************************************
  // disable only after enable bit already cleared
  // enable bit written as one re-enables at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      disabled_r <= 1'b0;
    else if (wr_done && paddr == ADDR_W'(RWDT_MODE_OFS) && wbyte[RWDT_EN_BIT])
      disabled_r <= 1'b0;
    else if (wr_done && paddr == ADDR_W'(RWDT_CMD_OFS) && wbyte == RWDT_CODE_DISABLE
             && !mode_en_r)
      disabled_r <= 1'b1;
  end

  // ****************************************
  // counter control
  // ****************************************
  // idle1/stop halts; idle2 follows run bit
  // bus release has no input here, so counting goes on
  assign halt = lp_sync_r[0] || (lp_sync_r[1] && !idle2_run_bit_r);
  // disabled state stops the counter, so no overflow
  assign cif.run = !disabled_r && !halt;
  // only the clear code clears; codes other than clear and disable do nothing
  assign cif.clr = wr_done && paddr == ADDR_W'(RWDT_CMD_OFS) && wbyte == RWDT_CODE_CLEAR;
  assign cif.sel = detection_time_select_r;
  assign cif.rst_en = reset_connect_bit_r;

  rwdt_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif)
  );

  // ****************************************
  // watchdog outputs
  // ****************************************
  // overflow gives a one-cycle non-maskable request and out pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nmi_r <= 1'b0;
      wdt_out_r <= 1'b0;
      wdt_reset_r <= 1'b0;
    end
    else
    begin
      nmi_r <= cif.ovf;
      wdt_out_r <= cif.ovf;
      wdt_reset_r <= cif.rst_active;
    end
  end

  // ****************************************
  // status, mask and interrupt
  // ****************************************
  // sticky events; a new event beats the clear-on-read
  // only the bits captured for the read are cleared, so an event that lands
  // between capture and completion is not lost
  always_comb
  begin
    status_nxt = status_r;
    if (rd_done && paddr == ADDR_W'(RWDT_STAT_OFS))
      status_nxt = status_r & ~prdata_r[1:0];
    if (cif.ovf)
      status_nxt[RWDT_ST_OVF] = 1'b1;
    if (cif.ovf && cif.rst_en)
      status_nxt[RWDT_ST_RST] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_r <= RWDT_STAT_RST;
    else
      status_r <= status_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= RWDT_MASK_RST;
    else if (wr_done && paddr == ADDR_W'(RWDT_MASK_OFS))
      mask_r <= wbyte[1:0];
  end

  // level interrupt, one cycle behind status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(status_r & mask_r);
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign watchdog_overflow_irq = nmi_r;
  assign wdt_out = wdt_out_r;
  assign wdt_reset = wdt_reset_r;
  assign irq = irq_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ovf_out;
    cif.ovf |=> watchdog_overflow_irq && wdt_out ##1 !watchdog_overflow_irq;
  endproperty
  a_ovf_out: assert property (p_ovf_out) else $error("overflow pulse missing");

  property p_no_rst_unconnected;
    !reset_connect_bit_r && !cif.rst_active |=> !cif.rst_active;
  endproperty
  a_no_rst_unconnected: assert property (p_no_rst_unconnected) else $error("reset unconnected");

  property p_disable_seq;
    $rose(disabled_r) |-> $past(wr_done && !mode_en_r
      && paddr == ADDR_W'(RWDT_CMD_OFS) && wbyte == RWDT_CODE_DISABLE);
  endproperty
  a_disable_seq: assert property (p_disable_seq) else $error("bad disable");

  property p_reenable;
    wr_done && paddr == ADDR_W'(RWDT_MODE_OFS) && wbyte[RWDT_EN_BIT] |=> !disabled_r;
  endproperty
  a_reenable: assert property (p_reenable) else $error("enable did not re-enable");

  property p_halt;
    lp_sync_r[0] |-> !cif.run;
  endproperty
  a_halt: assert property (p_halt) else $error("counter ran in idle1/stop");

  property p_idle2;
    lp_sync_r[1] && !lp_sync_r[0] && !disabled_r |-> cif.run == idle2_run_bit_r;
  endproperty
  a_idle2: assert property (p_idle2) else $error("idle2 run bit ignored");

  property p_other_code;
    wr_done && paddr == ADDR_W'(RWDT_CMD_OFS) && wbyte != RWDT_CODE_CLEAR
      && wbyte != RWDT_CODE_DISABLE |-> !cif.clr ##1 $stable(disabled_r);
  endproperty
  a_other_code: assert property (p_other_code) else $error("other code acted");

  property p_disabled_quiet;
    disabled_r |=> !watchdog_overflow_irq && !wdt_out;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("overflow while off");

  property p_frozen_off;
    disabled_r && !cif.clr |=> cif.count == $past(cif.count);
  endproperty
  a_frozen_off: assert property (p_frozen_off) else $error("counter moved while off");
endmodule
`default_nettype wire

// ===== verification/rwdt_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rwdt_pkg::*;
  // ****************************************
  // bench signals and model state
  // ****************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, code;
  logic [31:0] pwdata, prdata, rd, lfsr_r;
  logic idle1, idle2, ovf_irq, wdt_out, wdt_reset, irq;
  logic m_wen, m_run, m_i2;
  logic [1:0] m_sel;
  integer fails, checked, cyc, cnt, m_ovf, d_ovf, rst_len, rst_tot, per, ph;

  rwdt_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lp_idle1_stop(idle1),
    .lp_idle2(idle2), .watchdog_overflow_irq(ovf_irq), .wdt_out(wdt_out),
    .wdt_reset(wdt_reset), .irq(irq)
  );

  // free-running 4 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // automatic: the watcher and the main sequence call it in one time step
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task results;
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // ****************************************
  // apb master with model update at the completing edge
  // ****************************************
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 20);
    check("pready", pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // model sees the write only once it is accepted
    if (wr && a == RWDT_MODE_OFS)
    begin
      m_wen = d[7];
      m_sel = d[6:5];
      m_i2 = d[3];
      if (d[7])
        m_run = 1'b1;
    end
    if (wr && a == RWDT_CMD_OFS && d[7:0] == RWDT_CODE_CLEAR)
      cnt = 0;
    // disable needs the enable bit already cleared
    if (wr && a == RWDT_CMD_OFS && d[7:0] == RWDT_CODE_DISABLE && !m_wen)
      m_run = 1'b0;
  endtask

  task run(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // bounded wait for an overflow pulse
  task wait_pulse(input int lim);
    int n;
    n = 0;
    while (ovf_irq !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n = n + 1;
    end
    check("pulse_seen", n < lim, 1'b1);
  endtask

  // ****************************************
  // counter model, pulse and reset watchers, timeout
  // ****************************************
  // tolerance of 8 covers the two-flop pin sync and write/edge races
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc > 100000)
    begin
      fails = fails + 1;
      results();
    end
    per = 1 << (15 + 2 * m_sel);
    if (presetn && m_run && !idle1 && !(idle2 && !m_i2))
    begin
      cnt = cnt + 1;
      if (cnt % per == 0)
        m_ovf = m_ovf + 1;
    end
    if (ovf_irq === 1'b1)
    begin
      d_ovf = d_ovf + 1;
      ph = cnt % per;
      check("ovf_phase", ph <= 8 || ph >= per - 8, 1'b1);
    end
    check("wdt_out", wdt_out, ovf_irq);
    if (wdt_reset === 1'b1)
      rst_len = rst_len + 1;
    else if (rst_len != 0)
    begin
      check("rst_len", rst_len >= 22 && rst_len <= 29, 1'b1);
      rst_tot = rst_tot + 1;
      rst_len = 0;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {presetn, psel, penable, pwrite, idle1, idle2} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lfsr_r = 32'hc3b0e5a6;
    {fails, checked, cyc, cnt, m_ovf, d_ovf, rst_len, rst_tot} = '0;
    {m_wen, m_run, m_sel, m_i2} = 5'h18;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and the write-only command read
    apb(1'b0, RWDT_MODE_OFS, 32'h0);
    check("mode_rst", rd, 32'h80);
    apb(1'b0, RWDT_STAT_OFS, 32'h0);
    check("stat_rst", rd, 32'h0);
    apb(1'b0, RWDT_MASK_OFS, 32'h0);
    check("mask_rst", rd, 32'h0);
    apb(1'b0, RWDT_CMD_OFS, 32'h0);
    check("cmd_read", rd, 32'h0);
    // every detection time code, ending on the shortest
    for (int s = 3; s >= 0; s--)
    begin
      apb(1'b1, RWDT_MODE_OFS, 32'h84 | (s << 5));
      apb(1'b0, RWDT_MODE_OFS, 32'h0);
      check("mode_sel", rd, 32'h84 | (s << 5));
    end
    // random codes and unmapped places must change nothing
    repeat (3)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      code = lfsr_r[7:0];
      if (code == RWDT_CODE_CLEAR || code == RWDT_CODE_DISABLE)
        code = 8'h00;
      apb(1'b1, RWDT_CMD_OFS, {24'h0, code});
      apb(1'b1, {lfsr_r[15:12] | 4'h1, 4'h0}, lfsr_r);
      check("unmapped_err", err, 1'b1);
    end
    // overflow with reset connected and interrupt unmasked
    apb(1'b1, RWDT_MASK_OFS, 32'h1);
    apb(1'b1, RWDT_CMD_OFS, {24'h0, RWDT_CODE_CLEAR});
    wait_pulse(33000);
    run(40);
    check("irq_on", irq, 1'b1);
    check("rst_count", rst_tot, 1);
    apb(1'b0, RWDT_STAT_OFS, 32'h0);
    check("stat_ovf", rd, 32'h3);
    run(3);
    check("irq_off", irq, 1'b0);
    apb(1'b0, RWDT_STAT_OFS, 32'h0);
    check("stat_clr", rd, 32'h0);
    // disable needs both steps; a lone code is ignored
    apb(1'b1, RWDT_MODE_OFS, 32'h80);
    apb(1'b1, RWDT_MASK_OFS, 32'h0);
    apb(1'b1, RWDT_CMD_OFS, {24'h0, RWDT_CODE_CLEAR});
    apb(1'b1, RWDT_CMD_OFS, {24'h0, RWDT_CODE_DISABLE});
    run(20000);
    apb(1'b1, RWDT_MODE_OFS, 32'h0);
    run(2000);
    apb(1'b1, RWDT_CMD_OFS, {24'h0, RWDT_CODE_DISABLE});
    run(14000);
    check("no_ovf_off", d_ovf, 1);
    // re-enable without a code, then halt states
    apb(1'b1, RWDT_MODE_OFS, 32'h88);
    idle1 <= 1'b1;
    run(3000);
    idle1 <= 1'b0;
    idle2 <= 1'b1;
    run(3000);
    idle2 <= 1'b0;
    apb(1'b1, RWDT_MODE_OFS, 32'h80);
    idle2 <= 1'b1;
    run(3000);
    idle2 <= 1'b0;
    wait_pulse(12000);
    run(40);
    check("ovf_total", d_ovf, m_ovf);
    check("no_rst", rst_tot, 1);
    check("irq_masked", irq, 1'b0);
    apb(1'b0, RWDT_STAT_OFS, 32'h0);
    check("stat_ovf2", rd, 32'h1);
    results();
  end
endmodule
`default_nettype wire
